// ==== rtl/mpe_monitor_pwm_encoder.sv ====
// Monitor duty-cycle encoder: temperature and bus voltage as 31.5 kHz duty
// outputs, fault line encoding, AXI4-Lite register slave, one interrupt.
// Assumes sensor codes and fault inputs arrive asynchronously on pins.
`timescale 1ns/1ns
`default_nettype none

module mpe_monitor_pwm_encoder #(
   parameter int unsigned PWM_PERIOD = mpe_pkg::PWM_PERIOD_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output var  logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   input  wire logic [11:0] firstChannelThermistorIn,
   input  wire logic [11:0] secondChannelThermistorIn,
   input  wire logic [11:0] nonisolatedThermistorIn,
   input  wire logic [10:0] busVoltageIn,
   input  wire logic        desaturationFaultHi,
   input  wire logic        undervoltageLockoutHi,
   input  wire logic        desaturationFaultLo,
   input  wire logic        undervoltageLockoutLo,
   output var  logic        temperatureDutyOut,
   output var  logic        busVoltageDutyOut,
   output var  logic        highSideFaultLine,
   output var  logic        lowSideFaultLine,
   output var  logic        allFaultLine,
   output var  logic        driveEnableHi,
   output var  logic        driveEnableLo,
   output var  logic        irq
);

   if (PWM_PERIOD < 2 || PWM_PERIOD > 65535) begin
      $error("PWM_PERIOD out of range");
   end

   typedef struct packed {
      logic [50:0]        pinS1;
      logic [50:0]        pinS2;
      logic [11:0]        isoHold;
      logic signed [15:0] tempC;
      logic [15:0]        tDuty;
      logic [15:0]        vDuty;
      mpe_pkg::mpe_conv_t conv;
      logic [3:0]         ctrl;
      logic signed [15:0] tMin;
      logic signed [15:0] tMax;
      logic [15:0]        beta;
      logic [15:0]        rRef;
      logic [3:0]         status;
      logic [3:0]         mask;
      logic               irq;
      logic               hiLine;
      logic               loLine;
      logic               allLine;
      logic               enHi;
      logic               enLo;
      logic               awHeld;
      logic               wHeld;
      logic [7:0]         awAddr;
      logic [31:0]        wData;
      logic [3:0]         wStrb;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic [15:0]        perCnt;
      logic               perSeen;
   } mpe_state_t;

   mpe_state_t         st_r;
   mpe_state_t         st_nxt;
   logic               tEnd;
   logic               hiF;
   logic               loF;
   logic               cfgF;
   logic               act;
   logic [11:0]        codeSel;
   logic [15:0]        cc;
   logic signed [15:0] l2;
   logic [31:0]        kq;
   logic signed [47:0] prod;
   logic [10:0]        vb;
   logic [3:0]         clr;
   logic [3:0]         setEv;

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      clr = 4'h0;
      st_nxt.pinS1 = {firstChannelThermistorIn, secondChannelThermistorIn,
                      nonisolatedThermistorIn, busVoltageIn, desaturationFaultHi,
                      undervoltageLockoutHi, desaturationFaultLo, undervoltageLockoutLo};
      st_nxt.pinS2 = st_r.pinS1;
      hiF = st_r.pinS2[3] | st_r.pinS2[2];
      loF = st_r.pinS2[1] | st_r.pinS2[0];
      cfgF = st_r.ctrl[mpe_pkg::CTRL_CFGFAIL_BIT];
      act = st_r.ctrl[mpe_pkg::CTRL_POL_BIT];

      // Conversion, once per temperature period
      codeSel = st_r.ctrl[mpe_pkg::CTRL_SRC_BIT] ? st_r.pinS2[26:15] : st_r.isoHold;
      cc = (codeSel == 12'h000) ? 16'h0001 : {4'h0, codeSel};
      l2 = $signed({4'h0, mpe_pkg::log2_q8(cc)})
         - $signed({4'h0, mpe_pkg::log2_q8(16'(mpe_pkg::ADC_SPAN) - cc)})
         + $signed({4'h0, mpe_pkg::log2_q8(16'(mpe_pkg::PULLUP_OHM))})
         - $signed({4'h0, mpe_pkg::log2_q8((st_r.rRef == 16'h0) ? 16'h0001 : st_r.rRef)});
      kq = 32'(mpe_pkg::REF_TEMP_K_SQ * mpe_pkg::LN2_Q8)
         / ((st_r.beta == 16'h0) ? 32'h1 : {16'h0, st_r.beta});
      prod = $signed({16'h0, kq}) * $signed({{32{l2[15]}}, l2});
      vb = (busVoltageFull(st_r.pinS2[14:4])) ? 11'(mpe_pkg::FULL_SCALE_V) : st_r.pinS2[14:4];
      case (st_r.conv)
         mpe_pkg::MPE_IDLE: begin
            if (tEnd) begin
               // Isolated channel sample, first or second by CTRL_LOCH_BIT, crossed into the output domain
               st_nxt.isoHold = st_r.ctrl[mpe_pkg::CTRL_LOCH_BIT] ?
                                st_r.pinS2[38:27] : st_r.pinS2[50:39];
               st_nxt.conv = mpe_pkg::MPE_CALC;
            end
         end
         mpe_pkg::MPE_CALC: begin
            st_nxt.tempC = 16'(mpe_pkg::REF_TEMP_C) - 16'(prod >>> 16);
            st_nxt.conv = mpe_pkg::MPE_LOAD;
         end
         mpe_pkg::MPE_LOAD: begin
            if (st_r.tempC <= st_r.tMin || st_r.tMax <= st_r.tMin) begin
               st_nxt.tDuty = 16'h0000;
            end else if (st_r.tempC >= st_r.tMax) begin
               st_nxt.tDuty = 16'(PWM_PERIOD);
            end else begin
               st_nxt.tDuty = 16'(((32'(st_r.tempC) - 32'(st_r.tMin)) * PWM_PERIOD)
                              / (32'(st_r.tMax) - 32'(st_r.tMin)));
            end
            st_nxt.vDuty = 16'((32'(vb) * PWM_PERIOD) / mpe_pkg::FULL_SCALE_V);
            st_nxt.conv = mpe_pkg::MPE_IDLE;
         end
         default: begin
            st_nxt.conv = mpe_pkg::MPE_IDLE;
         end
      endcase

      // Fault lines and drive enables
      st_nxt.hiLine = (hiF | cfgF) ? act : ~act;
      st_nxt.loLine = (loF | cfgF) ? act : ~act;
      st_nxt.allLine = (hiF | loF | cfgF) ? act : ~act;
      st_nxt.enHi = ~(hiF | loF | cfgF);
      st_nxt.enLo = ~(hiF | loF | cfgF);

      // AXI4-Lite write channel
      if (s_axi_bready && st_r.bvalid) begin
         st_nxt.bvalid = 1'b0;
      end
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.awHeld = 1'b1;
         st_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.wHeld = 1'b1;
         st_nxt.wData = s_axi_wdata;
         st_nxt.wStrb = s_axi_wstrb;
      end
      if (st_nxt.awHeld && st_nxt.wHeld && !st_nxt.bvalid) begin
         st_nxt.awHeld = 1'b0;
         st_nxt.wHeld = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = mpe_pkg::RESP_OK;
         case ({st_nxt.awAddr[7:2], 2'b00})
            mpe_pkg::OFS_CTRL: begin
               if (st_nxt.wStrb[0]) begin
                  st_nxt.ctrl = st_nxt.wData[3:0];
               end
            end
            mpe_pkg::OFS_TMIN: st_nxt.tMin = mpe_pkg::merge_strb(st_r.tMin, st_nxt.wData, st_nxt.wStrb);
            mpe_pkg::OFS_TMAX: st_nxt.tMax = mpe_pkg::merge_strb(st_r.tMax, st_nxt.wData, st_nxt.wStrb);
            mpe_pkg::OFS_BETA: st_nxt.beta = mpe_pkg::merge_strb(st_r.beta, st_nxt.wData, st_nxt.wStrb);
            mpe_pkg::OFS_RREF: st_nxt.rRef = mpe_pkg::merge_strb(st_r.rRef, st_nxt.wData, st_nxt.wStrb);
            mpe_pkg::OFS_STATUS: clr = st_nxt.wStrb[0] ? st_nxt.wData[3:0] : 4'h0;
            mpe_pkg::OFS_MASK: begin
               if (st_nxt.wStrb[0]) begin
                  st_nxt.mask = st_nxt.wData[3:0];
               end
            end
            mpe_pkg::OFS_TEMP, mpe_pkg::OFS_DUTY: begin
            end
            default: st_nxt.bresp = mpe_pkg::RESP_ERR;
         endcase
      end
      st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.wHeld && !st_nxt.bvalid;

      // AXI4-Lite read channel
      if (s_axi_rready && st_r.rvalid) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = mpe_pkg::RESP_OK;
         case ({s_axi_araddr[7:2], 2'b00})
            mpe_pkg::OFS_CTRL:   st_nxt.rdata = {28'h0, st_r.ctrl};
            mpe_pkg::OFS_TMIN:   st_nxt.rdata = {16'h0, st_r.tMin};
            mpe_pkg::OFS_TMAX:   st_nxt.rdata = {16'h0, st_r.tMax};
            mpe_pkg::OFS_BETA:   st_nxt.rdata = {16'h0, st_r.beta};
            mpe_pkg::OFS_RREF:   st_nxt.rdata = {16'h0, st_r.rRef};
            mpe_pkg::OFS_STATUS: st_nxt.rdata = {28'h0, st_r.status};
            mpe_pkg::OFS_MASK:   st_nxt.rdata = {28'h0, st_r.mask};
            mpe_pkg::OFS_TEMP:   st_nxt.rdata = {16'h0, st_r.tempC};
            mpe_pkg::OFS_DUTY:   st_nxt.rdata = {st_r.vDuty, st_r.tDuty};
            default: begin
               st_nxt.rdata = 32'h0;
               st_nxt.rresp = mpe_pkg::RESP_ERR;
            end
         endcase
      end
      st_nxt.arready = !st_nxt.rvalid;

      // Sticky events; a set in the clearing cycle wins
      setEv = 4'h0;
      setEv[mpe_pkg::ST_HI_BIT] = hiF;
      setEv[mpe_pkg::ST_LO_BIT] = loF;
      setEv[mpe_pkg::ST_CFG_BIT] = cfgF;
      setEv[mpe_pkg::ST_CLAMP_BIT] = (st_r.conv == mpe_pkg::MPE_LOAD)
                                     && (st_r.tempC < st_r.tMin || st_r.tempC > st_r.tMax);
      st_nxt.status = (st_r.status & ~clr) | setEv;
      st_nxt.irq = |(st_nxt.status & st_nxt.mask);

      // Period watch for checking
      st_nxt.perCnt = tEnd ? 16'h0000 : st_r.perCnt + 16'h0001;
      st_nxt.perSeen = st_r.perSeen | tEnd;
   end

   function automatic logic busVoltageFull(input logic [10:0] v);
      return v > 11'(mpe_pkg::FULL_SCALE_V);
   endfunction

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.conv <= mpe_pkg::MPE_IDLE;
         st_r.ctrl <= mpe_pkg::CTRL_RST;
         st_r.tMin <= mpe_pkg::TMIN_RST;
         st_r.tMax <= mpe_pkg::TMAX_RST;
         st_r.beta <= mpe_pkg::BETA_RST;
         st_r.rRef <= mpe_pkg::RREF_RST;
         st_r.hiLine <= 1'b1;
         st_r.loLine <= 1'b1;
         st_r.allLine <= 1'b1;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Output channels
   // ----------------------------------------------------------------
   mpe_pwm_channel #(.PERIOD(PWM_PERIOD)) u_temp_pwm (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .duty      (st_r.tDuty),
      .pwmOut    (temperatureDutyOut),
      .periodEnd (tEnd)
   );

   mpe_pwm_channel #(.PERIOD(PWM_PERIOD)) u_volt_pwm (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .duty      (st_r.vDuty),
      .pwmOut    (busVoltageDutyOut),
      .periodEnd ()
   );

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign highSideFaultLine = st_r.hiLine;
   assign lowSideFaultLine = st_r.loLine;
   assign allFaultLine = st_r.allLine;
   assign driveEnableHi = st_r.enHi;
   assign driveEnableLo = st_r.enLo;
   assign irq = st_r.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   chk_pwm_period: assert property (tEnd && st_r.perSeen |-> st_r.perCnt == 16'(PWM_PERIOD - 1))
      else $error("temperature period length wrong");
   chk_temp_low: assert property (st_r.conv == mpe_pkg::MPE_LOAD && st_r.tempC <= st_r.tMin
      |=> st_r.tDuty == 16'h0000) else $error("temperature duty not clamped low");
   chk_temp_high: assert property (st_r.conv == mpe_pkg::MPE_LOAD && st_r.tempC >= st_r.tMax
      && st_r.tMax > st_r.tMin |=> st_r.tDuty == 16'(PWM_PERIOD)) else $error("duty not full");
   chk_volt_ratio: assert property (st_r.conv == mpe_pkg::MPE_LOAD |=>
      32'(st_r.vDuty) * mpe_pkg::FULL_SCALE_V <= 32'($past(vb)) * PWM_PERIOD
      && 32'(st_r.vDuty + 16'h1) * mpe_pkg::FULL_SCALE_V > 32'($past(vb)) * PWM_PERIOD)
      else $error("voltage duty ratio wrong");
   chk_ref_point: assert property (st_r.conv == mpe_pkg::MPE_CALC && cc == 16'h0800
      && st_r.rRef == 16'(mpe_pkg::PULLUP_OHM) |=> st_r.tempC == 16'(mpe_pkg::REF_TEMP_C))
      else $error("reference point not at reference temperature");
   chk_src_select: assert property (st_r.conv == mpe_pkg::MPE_CALC
      && !st_r.ctrl[mpe_pkg::CTRL_SRC_BIT] |-> codeSel == st_r.isoHold)
      else $error("isolated source not selected");
   chk_iso_hold: assert property (!(st_r.conv == mpe_pkg::MPE_IDLE && tEnd)
      |=> $stable(st_r.isoHold)) else $error("isolated sample moved outside transfer");
   chk_high_side_fault_line: assert property (hiF && !cfgF |=> !driveEnableHi && !driveEnableLo
      && highSideFaultLine == $past(act)) else $error("high-side fault not handled");
   chk_cfg_fail: assert property (cfgF |=> highSideFaultLine == $past(act)
      && lowSideFaultLine == $past(act) && allFaultLine == $past(act)
      && !driveEnableHi && !driveEnableLo) else $error("configuration failure pattern wrong");
   chk_idle_lines: assert property (!hiF && !loF && !cfgF |=> highSideFaultLine == !$past(act)
      && lowSideFaultLine == !$past(act) && allFaultLine == !$past(act))
      else $error("fault lines not inactive");
   chk_irq_level: assert property (hiF |=> st_r.status[mpe_pkg::ST_HI_BIT]
      && (irq || !st_r.mask[mpe_pkg::ST_HI_BIT])) else $error("high-side event not flagged");

   cov_clamp_high: cover property (st_r.conv == mpe_pkg::MPE_LOAD && st_r.tempC >= st_r.tMax);
   cov_high_side_fault_line: cover property (hiF && !loF);
   cov_cfg_fail: cover property ($rose(cfgF));
   cov_nonisolated: cover property (st_r.conv == mpe_pkg::MPE_CALC && st_r.ctrl[0]);

endmodule

`default_nettype wire

// ==== rtl/mpe_pkg.sv ====
// Package of the monitor duty-cycle encoder: register map, field positions,
// reset values, timing counts and shared arithmetic.
// Assumes a single 100 MHz system clock.
package mpe_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned PWM_FREQ_HZ    = 31_500;
   localparam int unsigned PWM_PERIOD_CYC = (CLK_HZ + PWM_FREQ_HZ / 2) / PWM_FREQ_HZ;

   // ----------------------------------------------------------------
   // Scaling constants
   // ----------------------------------------------------------------
   localparam int unsigned FULL_SCALE_V  = 1700;
   localparam int unsigned PULLUP_OHM    = 1330;
   localparam int          REF_TEMP_C    = 25;
   localparam int unsigned REF_TEMP_K_SQ = 298 * 298;
   localparam int unsigned LN2_Q8        = 177;
   localparam int unsigned ADC_SPAN      = 4096;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_TMIN   = 8'h04;
   localparam logic [7:0] OFS_TMAX   = 8'h08;
   localparam logic [7:0] OFS_BETA   = 8'h0c;
   localparam logic [7:0] OFS_RREF   = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_MASK   = 8'h18;
   localparam logic [7:0] OFS_TEMP   = 8'h1c;
   localparam logic [7:0] OFS_DUTY   = 8'h20;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_SRC_BIT     = 0;
   localparam int CTRL_LOCH_BIT    = 1;
   localparam int CTRL_POL_BIT     = 2;
   localparam int CTRL_CFGFAIL_BIT = 3;
   localparam int ST_HI_BIT        = 0;
   localparam int ST_LO_BIT        = 1;
   localparam int ST_CFG_BIT       = 2;
   localparam int ST_CLAMP_BIT     = 3;

   localparam logic [3:0]  CTRL_RST = 4'h0;
   localparam logic [15:0] TMIN_RST = 16'h0019;
   localparam logic [15:0] TMAX_RST = 16'h007d;
   localparam logic [15:0] BETA_RST = 16'h0fa0;
   localparam logic [15:0] RREF_RST = 16'h1388;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;

   typedef enum logic [2:0] {
      MPE_IDLE = 3'b001,
      MPE_CALC = 3'b010,
      MPE_LOAD = 3'b100
   } mpe_conv_t;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Base-two logarithm, 4 integer and 8 fraction bits, linear mantissa
   function automatic logic [11:0] log2_q8(input logic [15:0] x);
      logic [3:0]  m;
      logic [15:0] s;
      m = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (x[i]) begin
            m = 4'(i);
         end
      end
      s = x << (4'hf - m);
      return {m, s[14:7]};
   endfunction

   function automatic logic [15:0] merge_strb(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

endpackage

// ==== rtl/mpe_pwm_channel.sv ====
// One fixed-frequency duty-cycle output channel.
// Assumes the duty word is held stable by the caller; it is taken at period end.
`timescale 1ns/1ns
`default_nettype none

module mpe_pwm_channel #(
   parameter int unsigned PERIOD = mpe_pkg::PWM_PERIOD_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] duty,
   output var  logic        pwmOut,
   output var  logic        periodEnd
);

   if (PERIOD < 2 || PERIOD > 65535) begin
      $error("PERIOD out of range");
   end

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] hold;
      logic        out;
      logic        pend;
   } mpe_pwm_state_t;

   mpe_pwm_state_t st_r;
   mpe_pwm_state_t st_nxt;
   logic           last;

   // ----------------------------------------------------------------
   // Counter and compare
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      last = (st_r.cnt == 16'(PERIOD - 1));
      st_nxt.cnt = last ? 16'h0000 : st_r.cnt + 16'h0001;
      // New duty only at a period boundary, so no runt pulse
      st_nxt.hold = last ? duty : st_r.hold;
      st_nxt.out = (st_nxt.cnt < st_nxt.hold);
      st_nxt.pend = last;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pwmOut = st_r.out;
   assign periodEnd = st_r.pend;

endmodule

`default_nettype wire

// ==== tb/monitor_pwm_encoder_bench.sv ====
// Bench of the monitor duty-cycle encoder: bus tasks, scenarios, verdict.
// Assumes the design package and the host filter model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module monitor_pwm_encoder_bench;
   localparam int P = 100;
   logic        sys_clk = 1'h0, reset_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        desaturationFaultHi = 1'h0, undervoltageLockoutHi = 1'h0;
   logic        desaturationFaultLo = 1'h0, undervoltageLockoutLo = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [11:0] firstChannelThermistorIn = 12'h0, secondChannelThermistorIn = 12'h0;
   logic [11:0] nonisolatedThermistorIn = 12'h0;
   logic [10:0] busVoltageIn = 11'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, tLvl, vLvl;
   logic        temperatureDutyOut, busVoltageDutyOut, highSideFaultLine, lowSideFaultLine;
   logic        allFaultLine, driveEnableHi, driveEnableLo, irq;
   int          numErrors = 0, cmpCount = 0;

   mpe_monitor_pwm_encoder #(.PWM_PERIOD(P)) u_dut (.*);
   mpe_host_filter #(.P(P)) u_tf (.sys_clk(sys_clk), .pwm(temperatureDutyOut), .level(tLvl));
   mpe_host_filter #(.P(P)) u_vf (.sys_clk(sys_clk), .pwm(busVoltageDutyOut), .level(vLvl));

   always #5 sys_clk = ~sys_clk;

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmpCount++;
      if (s !== e) begin
         numErrors++;
         $display("wrong value %s: expected %h, seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk("bresp", 32'(s_axi_bresp), 32'(rsp));
      s_axi_bready <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rsp);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      chk("rdata", s_axi_rdata, e);
      chk("rresp", 32'(s_axi_rresp), 32'(rsp));
      s_axi_rready <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic testRegs();
      rdc(8'h04, 32'h19, 2'h0);
      rdc(8'h40, 32'h0, 2'h2);
      wr(8'h40, 32'h1, 2'h2);
      wr(8'h1c, 32'h5, 2'h0);
      rdc(8'h08, 32'h7d, 2'h0);
      $display("registers done");
   endtask

   task automatic testVolt();
      logic [10:0] v [4] = '{11'h352, 11'h6a4, 11'h154, 11'h7d0};
      foreach (v[i]) begin
         busVoltageIn <= v[i];
         repeat (3 * P) @(posedge sys_clk);
         chk("voltDuty", vLvl, 32'(v[i] > 1700 ? 1700 : v[i]) * P / 1700);
      end
      $display("voltage done");
   endtask

   task automatic testTemp();
      nonisolatedThermistorIn <= 12'h800;
      for (int s = 0; s < 3; s++) begin
         // Unused isolated channel inputs float to full code
         firstChannelThermistorIn <= (s == 0) ? 12'h800 : 12'hfff;
         secondChannelThermistorIn <= (s == 2) ? 12'h800 : 12'hfff;
         wr(8'h00, 32'(s), 2'h0);
         wr(8'h04, 32'hc8, 2'h0);
         wr(8'h08, 32'h12c, 2'h0);
         repeat (3 * P) @(posedge sys_clk);
         chk("tempLow", tLvl, 32'h0);
         wr(8'h04, 32'hffc4, 2'h0);
         wr(8'h08, 32'hffce, 2'h0);
         repeat (3 * P) @(posedge sys_clk);
         chk("tempHigh", tLvl, P);
      end
      // Divider at the reference resistance reads the reference temperature
      wr(8'h10, 32'h532, 2'h0);
      wr(8'h04, 32'h0, 2'h0);
      wr(8'h08, 32'h64, 2'h0);
      repeat (3 * P) @(posedge sys_clk);
      chk("tempMid", tLvl, 32'(25 * P / 100));
      rdc(8'h1c, 32'h19, 2'h0);
      $display("temperature done");
   endtask

   task automatic testFault();
      wr(8'h18, 32'h1, 2'h0);
      for (int k = 0; k < 2; k++) begin
         desaturationFaultHi <= 1'(k == 0);
         undervoltageLockoutHi <= 1'(k == 1);
         repeat (5) @(posedge sys_clk);
         chk("hiFault", 32'({highSideFaultLine, lowSideFaultLine, allFaultLine,
             driveEnableHi, driveEnableLo, irq}), 32'h11);
         desaturationFaultHi <= 1'h0;
         undervoltageLockoutHi <= 1'h0;
         repeat (5) @(posedge sys_clk);
         wr(8'h14, 32'h1, 2'h0);
         repeat (2) @(posedge sys_clk);
         chk("cleared", 32'({highSideFaultLine, lowSideFaultLine, allFaultLine, irq}), 32'he);
      end
      $display("fault done");
   endtask

   task automatic testCfg();
      wr(8'h00, 32'h8, 2'h0);
      repeat (3) @(posedge sys_clk);
      chk("cfgFail", 32'({highSideFaultLine, lowSideFaultLine, allFaultLine,
          driveEnableHi, driveEnableLo}), 32'h0);
      wr(8'h00, 32'h4, 2'h0);
      repeat (3) @(posedge sys_clk);
      chk("activeHigh", 32'({highSideFaultLine, lowSideFaultLine, allFaultLine}), 32'h0);
      $display("configuration done");
   endtask

   task automatic finishTest();
      $display("compares %0d, mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      testRegs();
      testVolt();
      testTemp();
      testFault();
      testCfg();
      finishTest();
   end

   initial begin
      #500000;
      numErrors++;
      finishTest();
   end
endmodule

`default_nettype wire

// ==== tb/mpe_host_filter.sv ====
// Host board filter model: averages one duty output over one period.
// Assumes the duty output changes only just after rising clock edges.
`timescale 1ns/1ns
`default_nettype none

module mpe_host_filter #(
   parameter int P = 100
) (
   input  wire logic        sys_clk,
   input  wire logic        pwm,
   output var  logic [31:0] level
);
   logic [P-1:0] hist = '0;

   // Moving average over one period stands in for the low-pass filter
   always @(posedge sys_clk) hist <= {hist[P-2:0], pwm};
   assign level = 32'($countones(hist));
endmodule

`default_nettype wire
